// ===== volt_prot_pkg.sv
// Shared constants and types of the voltage protection element
package volt_prot_pkg;
  localparam int unsigned VW = 16;
  localparam int unsigned TW = 24;
  localparam int unsigned PCT_W = 8;
  localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
  localparam logic [PCT_W-1:0] PLOSS_PCT = 8'h03;
  // One over root three scaled by 2^14 for nominal derivation
  localparam logic [VW-1:0] INV_SQRT3_Q14 = 16'h24F3;
  localparam int unsigned Q_SHIFT = 14;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned AVG_WINDOW_MIN = 10;
  localparam longint unsigned AVG_WINDOW_CYC = 64'(AVG_WINDOW_MIN) * 60 * CLK_HZ;
  localparam int unsigned AVG_SAMPLES = 16;
  localparam int unsigned AVG_IW = 4;
  localparam logic [1:0] METH_FUND = 2'h0;
  localparam logic [1:0] METH_RMS = 2'h1;
  localparam logic [1:0] METH_AVG = 2'h2;
  localparam logic [1:0] PICK_ONE = 2'h0;
  localparam logic [1:0] PICK_TWO = 2'h1;
  localparam logic [1:0] PICK_ALL = 2'h2;
  typedef enum logic {MODE_OVER, MODE_UNDER} elem_mode_t;
  typedef enum logic {CONN_PG, CONN_PP} conn_t;
endpackage

// ===== avg_if.sv
// Carrier between the element and its sliding average unit
`timescale 1ns/10ps
interface avg_if;
  logic [volt_prot_pkg::VW-1:0] inst [3];
  logic [volt_prot_pkg::VW-1:0] avg [3];
  modport src (output inst, input avg);
  modport unit (input inst, output avg);
endinterface

// ===== sliding_avg.sv
// Sliding average of three voltages over a long window
`timescale 1ns/10ps
module sliding_avg #(
  parameter longint unsigned WINDOW_CYC = volt_prot_pkg::AVG_WINDOW_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  avg_if.unit av
);
  localparam longint unsigned STEP = WINDOW_CYC / volt_prot_pkg::AVG_SAMPLES;
  localparam int unsigned SW = volt_prot_pkg::VW + volt_prot_pkg::AVG_IW;
  logic [39:0] tick_ff;
  logic [volt_prot_pkg::AVG_IW-1:0] wr_ff;
  logic [volt_prot_pkg::VW-1:0] mem_ff [3][volt_prot_pkg::AVG_SAMPLES];
  logic [SW-1:0] sum_ff [3];
  logic step_w;
  assign step_w = (tick_ff == 40'(STEP - 1));

  ////////////////////////////////////////////////////////////////
  // Sample cadence
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_ff <= '0;
      wr_ff <= '0;
    end else if (step_w) begin
      tick_ff <= '0;
      wr_ff <= wr_ff + 1'b1;
    end else begin
      tick_ff <= tick_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Ring of samples and running sum per phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int p = 0; p < 3; p++) begin
        sum_ff[p] <= '0;
        for (int s = 0; s < volt_prot_pkg::AVG_SAMPLES; s++) begin
          mem_ff[p][s] <= '0;
        end
      end
    end else if (step_w) begin
      for (int p = 0; p < 3; p++) begin
        mem_ff[p][wr_ff] <= av.inst[p];
        sum_ff[p] <= sum_ff[p] + SW'(av.inst[p]) - SW'(mem_ff[p][wr_ff]);
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      av.avg[p] = sum_ff[p][SW-1:volt_prot_pkg::AVG_IW];
    end
  end
endmodule

// ===== voltage_protection_element.sv
// Over/undervoltage protection element with blocking and minimum current release
//
// Function
// - Mode setting selects overvoltage or undervoltage operation.
// - Compared quantity is fundamental, true RMS or sliding average.
// - Undervoltage with average method supervises a ten-minute sliding average.
// - Phase-to-ground wiring: nominal is rating over root three, or rating.
// - Phase-to-phase wiring ignores measuring mode; nominal equals rating.
// - Minimum current release blocks undervoltage once all currents are below threshold.
// - Release needs any current above threshold, then the release delay.
// - Current release acts only when enabled and in undervoltage mode.
// - Current release always uses the neutral-side current inputs.
// - Pickup needs one, two or all three phases, by setting.
// - Dropout ratio is a setting, as percent of pickup threshold.
// - Alarm and trip flags per phase one to three.
// - External block input with activation setting.
// - Fuse failure from supervision blocks when circuit supervision is active.
// - Loss-of-potential threshold fixed at three percent of nominal blocks undervoltage.
`timescale 1ns/10ps
module voltage_protection_element #(
  parameter longint unsigned AVG_WINDOW_CYC = volt_prot_pkg::AVG_WINDOW_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [volt_prot_pkg::VW-1:0] v_fund_i [3],
  input wire logic [volt_prot_pkg::VW-1:0] v_rms_i [3],
  input wire logic [volt_prot_pkg::VW-1:0] i_ntrl_i [3],
  input wire logic [volt_prot_pkg::VW-1:0] i_term_i [3],
  input wire logic elem_mode_i,
  input wire logic [1:0] meas_method_i,
  input wire logic meas_mode_pp_i,
  input wire logic transformer_connection_type_i,
  input wire logic [volt_prot_pkg::VW-1:0] vt_sec_i,
  input wire logic [volt_prot_pkg::PCT_W-1:0] pickup_pct_i,
  input wire logic [volt_prot_pkg::PCT_W-1:0] dropout_pct_i,
  input wire logic [1:0] pickup_count_i,
  input wire logic [volt_prot_pkg::TW-1:0] trip_delay_i,
  input wire logic imin_enable_i,
  input wire logic [volt_prot_pkg::VW-1:0] imin_threshold_i,
  input wire logic [volt_prot_pkg::TW-1:0] imin_delay_i,
  input wire logic external_block_source_i,
  input wire logic external_block_activation_i,
  input wire logic meas_circuit_superv_i,
  input wire logic transformer_supervisor_fail_i,
  input wire logic potential_loss_supervisor_en_i,
  output logic [2:0] alarm_o,
  output logic [2:0] trip_o,
  output logic blocked_o,
  output logic [volt_prot_pkg::VW-1:0] v_nom_o
);
  logic [1:0] xb_sync_ff;
  logic [1:0] fuse_sync_ff;
  logic [2:0] pick_ff;
  logic [volt_prot_pkg::TW-1:0] trip_cnt_ff;
  logic [volt_prot_pkg::TW-1:0] rel_cnt_ff;
  logic cur_block_ff;
  logic [2:0] alarm_ff;
  logic [2:0] trip_ff;
  logic blocked_ff;
  logic [volt_prot_pkg::VW-1:0] v_nom_ff;
  logic [volt_prot_pkg::VW-1:0] vsel [3];
  logic [volt_prot_pkg::VW-1:0] nxt_v_nom;
  logic [31:0] pick_lvl;
  logic [31:0] drop_lvl;
  logic [31:0] ploss_lvl;
  logic [2:0] nxt_pick;
  logic under_w;
  logic all_dead_w;
  logic group_w;
  logic ploss_w;
  logic block_w;
  avg_if av ();

  function automatic logic [31:0] pct_of(input logic [15:0] base, input logic [7:0] pct);
    pct_of = (32'(base) * 32'(pct)) / 32'(volt_prot_pkg::PCT_FULL);
  endfunction

  function automatic logic [1:0] ones3(input logic [2:0] v);
    ones3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Measured quantity and averaging
  assign av.inst = v_rms_i;
  sliding_avg #(.WINDOW_CYC(AVG_WINDOW_CYC)) u_avg (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .av(av)
  );

  assign under_w = (elem_mode_i == volt_prot_pkg::MODE_UNDER);

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (meas_method_i == volt_prot_pkg::METH_RMS) begin
        vsel[p] = v_rms_i[p];
      end else if (meas_method_i == volt_prot_pkg::METH_AVG) begin
        vsel[p] = av.avg[p];
      end else begin
        vsel[p] = v_fund_i[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Nominal voltage
  always_comb begin
    if (transformer_connection_type_i == volt_prot_pkg::CONN_PP || meas_mode_pp_i) begin
      nxt_v_nom = vt_sec_i;
    end else begin
      nxt_v_nom = 16'((32'(vt_sec_i) * 32'(volt_prot_pkg::INV_SQRT3_Q14)) >> volt_prot_pkg::Q_SHIFT);
    end
  end

  assign pick_lvl = pct_of(v_nom_ff, pickup_pct_i);
  assign drop_lvl = pct_of(16'(pick_lvl), dropout_pct_i);
  assign ploss_lvl = pct_of(v_nom_ff, volt_prot_pkg::PLOSS_PCT);

  ////////////////////////////////////////////////////////////////
  // Per-phase pickup with hysteresis
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (under_w) begin
        nxt_pick[p] = pick_ff[p] ? (32'(vsel[p]) < drop_lvl) : (32'(vsel[p]) < pick_lvl);
      end else begin
        nxt_pick[p] = pick_ff[p] ? (32'(vsel[p]) > drop_lvl) : (32'(vsel[p]) > pick_lvl);
      end
    end
  end

  always_comb begin
    if (pickup_count_i == volt_prot_pkg::PICK_ALL) begin
      group_w = (ones3(pick_ff) == 2'h3);
    end else if (pickup_count_i == volt_prot_pkg::PICK_TWO) begin
      group_w = (ones3(pick_ff) >= 2'h2);
    end else begin
      group_w = (pick_ff != 3'h0);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Blocking
  assign all_dead_w = (i_ntrl_i[0] < imin_threshold_i) && (i_ntrl_i[1] < imin_threshold_i)
                      && (i_ntrl_i[2] < imin_threshold_i);
  assign ploss_w = potential_loss_supervisor_en_i && under_w &&
                   (32'(vsel[0]) < ploss_lvl) && (32'(vsel[1]) < ploss_lvl) && (32'(vsel[2]) < ploss_lvl);
  assign block_w = (xb_sync_ff[1] && external_block_activation_i)
                   || (fuse_sync_ff[1] && meas_circuit_superv_i)
                   || ploss_w
                   || (cur_block_ff && imin_enable_i && under_w);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xb_sync_ff <= '0;
      fuse_sync_ff <= '0;
    end else begin
      xb_sync_ff <= {xb_sync_ff[0], external_block_source_i};
      fuse_sync_ff <= {fuse_sync_ff[0], transformer_supervisor_fail_i};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_block_ff <= 1'b0;
      rel_cnt_ff <= '0;
    end else if (!(imin_enable_i && under_w)) begin
      cur_block_ff <= 1'b0;
      rel_cnt_ff <= '0;
    end else if (all_dead_w) begin
      cur_block_ff <= 1'b1;
      rel_cnt_ff <= '0;
    end else if (cur_block_ff) begin
      if (rel_cnt_ff >= imin_delay_i) begin
        cur_block_ff <= 1'b0;
      end else begin
        rel_cnt_ff <= rel_cnt_ff + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pickup, trip timing and outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pick_ff <= '0;
      trip_cnt_ff <= '0;
    end else if (block_w) begin
      pick_ff <= '0;
      trip_cnt_ff <= '0;
    end else begin
      pick_ff <= nxt_pick;
      if (!group_w) begin
        trip_cnt_ff <= '0;
      end else if (trip_cnt_ff < trip_delay_i) begin
        trip_cnt_ff <= trip_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm_ff <= '0;
      trip_ff <= '0;
      blocked_ff <= 1'b0;
      v_nom_ff <= '0;
    end else begin
      alarm_ff <= (group_w && !block_w) ? pick_ff : 3'h0;
      trip_ff <= (group_w && !block_w && trip_cnt_ff >= trip_delay_i) ? pick_ff : 3'h0;
      blocked_ff <= block_w;
      v_nom_ff <= nxt_v_nom;
    end
  end

  assign alarm_o = alarm_ff;
  assign trip_o = trip_ff;
  assign blocked_o = blocked_ff;
  assign v_nom_o = v_nom_ff;
endmodule

// ===== meas_model.sv
// Model of the measurement modules feeding the element
`timescale 1ns/10ps
module meas_model (
  input wire logic [15:0] vf_i [3],
  input wire logic [15:0] vr_i [3],
  input wire logic [15:0] ic_i [3],
  input wire logic [15:0] it_i [3],
  output logic [15:0] v_fund_o [3],
  output logic [15:0] v_rms_o [3],
  output logic [15:0] i_ntrl_o [3],
  output logic [15:0] i_term_o [3]
);
  assign v_fund_o = vf_i;
  assign v_rms_o = vr_i;
  // Neutral side and terminal side currents kept apart
  assign i_ntrl_o = ic_i;
  assign i_term_o = it_i;
endmodule

// ===== vpe_assertions.sv
// Port checker of the voltage protection element
`timescale 1ns/10ps
module vpe_assertions (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] i_ntrl_i [3],
  input wire logic elem_mode_i,
  input wire logic meas_mode_pp_i,
  input wire logic transformer_connection_type_i,
  input wire logic [15:0] vt_sec_i,
  input wire logic imin_enable_i,
  input wire logic [15:0] imin_threshold_i,
  input wire logic external_block_source_i,
  input wire logic external_block_activation_i,
  input wire logic meas_circuit_superv_i,
  input wire logic transformer_supervisor_fail_i,
  input wire logic [2:0] alarm_o,
  input wire logic [2:0] trip_o,
  input wire logic blocked_o,
  input wire logic [15:0] v_nom_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic lo;
  assign lo = i_ntrl_i[0] < imin_threshold_i && i_ntrl_i[1] < imin_threshold_i && i_ntrl_i[2] < imin_threshold_i;
  a_reset_quiet: assert property ($rose(arst_n_i) |-> alarm_o == 3'h0 && trip_o == 3'h0)
    else $error("outputs set after reset");
  a_trip_alarm: assert property ((trip_o & ~alarm_o) == 3'h0)
    else $error("trip without alarm");
  a_trip_late: assert property ($rose(trip_o[0]) |-> $past(alarm_o[0]))
    else $error("trip before alarm");
  a_ext_block: assert property ((external_block_activation_i && external_block_source_i) [*5]
    |-> blocked_o && alarm_o == 3'h0) else $error("external block ignored");
  a_fuse_block: assert property ((meas_circuit_superv_i && transformer_supervisor_fail_i) [*5]
    |-> blocked_o && alarm_o == 3'h0) else $error("fuse failure ignored");
  a_vnom_pp: assert property ($past(arst_n_i) && transformer_connection_type_i && $stable(vt_sec_i)
    && $stable(transformer_connection_type_i) |-> v_nom_o == vt_sec_i) else $error("nominal wrong");
  a_imin_block: assert property ((imin_enable_i && elem_mode_i && lo) [*3] |-> blocked_o)
    else $error("min current block missing");
  a_imin_hold: assert property (imin_enable_i && elem_mode_i && $fell(lo) && blocked_o |=> blocked_o)
    else $error("release too early");
endmodule
bind voltage_protection_element vpe_assertions u_vpe_assertions (.clk_i, .arst_n_i, .i_ntrl_i, .elem_mode_i,
  .meas_mode_pp_i, .transformer_connection_type_i, .vt_sec_i, .imin_enable_i, .imin_threshold_i,
  .external_block_source_i, .external_block_activation_i, .meas_circuit_superv_i,
  .transformer_supervisor_fail_i, .alarm_o, .trip_o, .blocked_o, .v_nom_o);

// ===== voltage_protection_element_bench.sv
// Testbench of the voltage protection element
`timescale 1ns/10ps
module voltage_protection_element_bench;
  logic clk_i, arst_n_i, mode, mpp, conn, ien, esrc, eact, mcs, tf, ploss, blk;
  logic [15:0] vf [3], vr [3], ic [3], it [3], vfo [3], vro [3], ico [3], ito [3], vt, ithr, vnom;
  logic [1:0] meth, pcnt;
  logic [7:0] pu, dr;
  logic [23:0] tdel, idel;
  logic [2:0] alm, trp;
  int errors = 0, n_tests = 0;
  meas_model u_meas_model (.vf_i(vf), .vr_i(vr), .ic_i(ic), .it_i(it), .v_fund_o(vfo), .v_rms_o(vro),
    .i_ntrl_o(ico), .i_term_o(ito));
  voltage_protection_element #(.AVG_WINDOW_CYC(160)) u_voltage_protection_element (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .v_fund_i(vfo), .v_rms_i(vro), .i_ntrl_i(ico), .i_term_i(ito), .elem_mode_i(mode),
    .meas_method_i(meth), .meas_mode_pp_i(mpp), .transformer_connection_type_i(conn), .vt_sec_i(vt),
    .pickup_pct_i(pu), .dropout_pct_i(dr), .pickup_count_i(pcnt), .trip_delay_i(tdel), .imin_enable_i(ien),
    .imin_threshold_i(ithr), .imin_delay_i(idel), .external_block_source_i(esrc),
    .external_block_activation_i(eact), .meas_circuit_superv_i(mcs), .transformer_supervisor_fail_i(tf),
    .potential_loss_supervisor_en_i(ploss), .alarm_o(alm), .trip_o(trp), .blocked_o(blk), .v_nom_o(vnom));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task setv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    vf = '{a, b, c};
    vr = '{a, b, c};
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task t_nom;
    conn = 1'b0;
    cyc(3); chk("vnom pg", 16'($rtoi(16384.0 / $sqrt(3.0))), vnom);
    mpp = 1'b1;
    cyc(3); chk("vnom pg pp", 16'h4000, vnom);
    conn = 1'b1; mpp = 1'b0;
    cyc(3); chk("vnom pp", 16'h4000, vnom);
  endtask
  task t_trip;
    pcnt = volt_prot_pkg::PICK_ALL; setv(16'h1F40, 16'h1F40, 16'h1F40);
    cyc(4); chk("alarm", 16'h0007, 16'(alm));
    cyc(5); chk("trip early", 16'h0000, 16'(trp));
    cyc(6); chk("trip", 16'h0007, 16'(trp));
    setv(16'h3E80, 16'h3E80, 16'h3E80);
    cyc(4); chk("trip clear", 16'h0000, 16'({alm, trp}));
  endtask
  task t_count;
    pcnt = volt_prot_pkg::PICK_ONE; setv(16'h1F40, 16'h3E80, 16'h3E80);
    cyc(4); chk("one phase", 16'h0001, 16'(alm));
    pcnt = volt_prot_pkg::PICK_TWO;
    cyc(4); chk("two of one", 16'h0000, 16'(alm));
    setv(16'h1F40, 16'h1F40, 16'h3E80);
    cyc(4); chk("two phases", 16'h0003, 16'(alm));
    setv(16'h3E80, 16'h3E80, 16'h3E80); pcnt = volt_prot_pkg::PICK_ONE;
  endtask
  task t_over;
    mode = 1'b0; pu = 8'h6E; dr = 8'h5F; meth = volt_prot_pkg::METH_RMS; vr = '{3{16'h4A38}};
    cyc(4); chk("over rms", 16'h0007, 16'(alm));
    vr = '{3{16'h445C}};
    cyc(4); chk("dropout hold", 16'h0007, 16'(alm));
    meth = volt_prot_pkg::METH_FUND;
    cyc(4); chk("fund clear", 16'h0000, 16'(alm));
    meth = volt_prot_pkg::METH_RMS;
    cyc(4); chk("no repickup", 16'h0000, 16'(alm));
    mode = 1'b1; pu = 8'h50; dr = 8'h69; meth = volt_prot_pkg::METH_FUND;
  endtask
  task t_block;
    setv(16'h1F40, 16'h1F40, 16'h1F40); esrc = 1'b1; eact = 1'b1;
    cyc(6); chk("ext block", 16'h0001, 16'({alm, blk}));
    eact = 1'b0;
    cyc(6); chk("ext inactive", 16'h000E, 16'({alm, blk}));
    esrc = 1'b0; mcs = 1'b1; tf = 1'b1;
    cyc(6); chk("fuse block", 16'h0001, 16'({alm, blk}));
    mcs = 1'b0;
    cyc(6); chk("fuse off", 16'h0000, 16'(blk));
    tf = 1'b0; ploss = 1'b1; setv(16'h0000, 16'h0000, 16'h0000);
    cyc(6); chk("lop block", 16'h0001, 16'(blk));
    ploss = 1'b0;
  endtask
  task t_imin;
    setv(16'h1F40, 16'h1F40, 16'h1F40); ien = 1'b1; ic = '{3{16'h0064}};
    cyc(4); chk("imin block", 16'h0001, 16'({alm, blk}));
    ic[1] = 16'h1388;
    cyc(10); chk("imin wait", 16'h0001, 16'(blk));
    cyc(20); chk("imin release", 16'h000E, 16'({alm, blk}));
    ic = '{3{16'h0064}}; mode = 1'b0;
    cyc(4); chk("imin over", 16'h0000, 16'(blk));
    mode = 1'b1; ien = 1'b0;
    cyc(4); chk("imin off", 16'h000E, 16'({alm, blk}));
  endtask
  task t_rst;
    cyc(10);
    chk("trip before reset", 16'h0007, 16'(trp));
    arst_n_i = 1'b0;
    cyc(1);
    chk("reset outputs", 16'h0000, 16'({alm, trp, blk}));
    chk("reset vnom", 16'h0000, vnom);
    arst_n_i = 1'b1;
    cyc(1);
    chk("vnom after reset", 16'h4000, vnom);
    chk("no alarm yet", 16'h0000, 16'(alm));
    cyc(3);
    chk("alarm after reset", 16'h0007, 16'(alm));
  endtask
  task t_avg;
    setv(16'h3E80, 16'h3E80, 16'h3E80);
    cyc(170);
    meth = volt_prot_pkg::METH_AVG;
    cyc(4);
    chk("avg steady", 16'h0000, 16'(alm));
    vr = '{3{16'h1F40}};
    cyc(4);
    chk("avg lag", 16'h0000, 16'(alm));
    cyc(170);
    chk("avg alarm", 16'h0007, 16'(alm));
    meth = volt_prot_pkg::METH_FUND;
  endtask
  initial begin
    arst_n_i = 1'b0; mode = 1'b1; mpp = 1'b0; conn = 1'b1; ien = 1'b0; esrc = 1'b0; eact = 1'b0;
    mcs = 1'b0; tf = 1'b0; ploss = 1'b0; vt = 16'h4000; ithr = 16'h03E8; meth = volt_prot_pkg::METH_FUND;
    pcnt = volt_prot_pkg::PICK_ONE; pu = 8'h50; dr = 8'h69; idel = 24'h000014;
    tdel = 24'h00000A;
    setv(16'h3E80, 16'h3E80, 16'h3E80); ic = '{3{16'h1388}}; it = '{3{16'h1388}};
    cyc(3); arst_n_i = 1'b1;
    cyc(2); t_nom; t_trip; t_count; t_over; t_block; t_imin;
    t_rst;
    t_avg;
    print_verdict;
  end
  initial begin
    #1000000;
    errors++;
    print_verdict;
  end
endmodule
